// ===== hw/sdts_core.sv
// SDRAM timing enforcement, CKE control and mode register loading
// Function
// - Setting CKE bit issues power-down exit
// - CKE pin follows CKE bit, low at reset
// - Self-refresh holds CKE low 4..11 cycles
// - Active to read/write waits 1..4 cycles
// - Precharge to active waits 1..8 cycles
// - Write recovery delay coded 1..4 cycles
// - Write to active waits recovery plus precharge
// - Refresh to active waits odd 1..15 cycles
// - Self-refresh exit waits same refresh delay
// - Read data captured after latency 2 or 3
// - Bits 16 and 7 read zero
// - Mode value ten bits, write only, address pins
// - Mode value taken from window offset
// - Mode value undefined until written
// - Window write: precharge-all or mode set
// - Clearing CKE bit issues power-down if enabled
`timescale 1ns/1ps
module sdts_core #(
  parameter int DATA_W = 32
) (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     busSel,
  input  wire logic                     busWe,
  input  wire logic [15:0]              busAddr,
  input  wire logic [31:0]              busWdata,
  output logic      [31:0]              busRdata,
  output logic                          busAck,
  input  wire logic                     clockOutputEnable,
  input  wire logic                     reqValid,
  input  wire sdts_pkg::sdts_req_t      req,
  output logic                          reqReady,
  input  wire logic                     sdClk,
  output sdts_pkg::sdts_pins_t          sdPins,
  input  wire logic [DATA_W-1:0]        sdDataIn,
  output logic      [DATA_W-1:0]        readData,
  output logic                          readValid
);
  import sdts_pkg::*;

  if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
    $error("DATA_W out of range");
  end

  // SDRAM clock edge finder
  logic [2:0]        clkSync;
  logic [DATA_W-1:0] dataSync1;
  logic [DATA_W-1:0] dataSync2;
  wire               tick = clkSync[1] & ~clkSync[2];

  logic [31:0]       ctrl;
  logic [MODE_W-1:0] modeValue;
  logic              pendMode;
  logic              pendExitPd;
  logic              pendEnterPd;
  logic [4:0]        actWait;
  logic [4:0]        rwWait;
  logic [4:0]        ckeWait;
  logic [4:0]        exitWait;
  logic [1:0]        rdCount;
  logic              rdBusy;
  sdts_state_e       state;

  // Register decode
  wire ctrlHit  = busSel && busAddr == CTRL_OFFSET;
  wire modeHit  = busSel && (busAddr & MODE_SPAN_MASK) == MODE_BASE;
  wire ctrlWr   = ctrlHit && busWe;
  wire modeWr   = modeHit && busWe;
  wire [31:0] ctrlWrVal = busWdata & CTRL_HELD_MASK;
  wire ckeRise  = ctrlWr && ctrlWrVal[CKE_LEVEL_BIT] && !ctrl[CKE_LEVEL_BIT];
  wire ckeFall  = ctrlWr && !ctrlWrVal[CKE_LEVEL_BIT] && ctrl[CKE_LEVEL_BIT];

  // Field decode into cycle counts minus one
  wire [4:0] ckeLowN = CKE_LOW_BASE + {2'h0, ctrl[CKE_LOW_LSB +: 3]} - 5'h01;
  wire [4:0] actRwN  = {3'h0, ctrl[ACT_RW_LSB +: 2]};
  wire [4:0] preActN = {2'h0, ctrl[PRE_ACT_LSB +: 3]};
  wire [4:0] wrRecN  = {3'h0, ctrl[WR_REC_LSB +: 2]};
  wire [4:0] refActN = {1'b0, ctrl[REF_ACT_LSB +: 3], 1'b0};
  wire [4:0] wrActN  = wrRecN + preActN + 5'h01;
  wire [1:0] rdLat   = ctrl[RD_LAT_LSB +: 2];
  wire       rdLatOk = rdLat == RD_LAT_TWO || rdLat == RD_LAT_THREE;

  wire isAct   = req.kind == REQ_ACT;
  wire isRw    = req.kind == REQ_READ || req.kind == REQ_WRITE;
  wire isExit  = req.kind == REQ_EXIT;
  wire inRun   = state == ST_RUN;
  wire regBusy = pendMode || pendExitPd || pendEnterPd;
  wire reqOk   = (inRun && !isExit && !(isAct && actWait != 5'h00)
                  && !(isRw && rwWait != 5'h00)
                  && !(req.kind == REQ_READ && (!rdLatOk || rdBusy)))
                 || (state == ST_SELF && isExit && ckeWait == 5'h00);
  assign reqReady = tick && !regBusy && reqValid && reqOk;
  wire   issue    = reqReady;

  // Command selection
  sdts_cmd_t         next_cmd;
  logic [ADDR_W-1:0] next_addr;
  always_comb begin
    next_cmd  = CMD_NOP;
    next_addr = '0;
    if (pendMode && inRun) begin
      next_cmd = ctrl[MODE_SET_BIT] ? CMD_MRS : CMD_PRE;
      if (ctrl[MODE_SET_BIT]) begin
        next_addr = {{(ADDR_W-MODE_W){1'b0}}, modeValue};
      end else begin
        next_addr[PALL_ADDR_BIT] = 1'b1;
      end
    end else if (issue) begin
      next_addr = req.addr;
      unique case (req.kind)
        REQ_ACT:   next_cmd = CMD_ACT;
        REQ_READ:  next_cmd = CMD_READ;
        REQ_WRITE: next_cmd = CMD_WRITE;
        REQ_PRE:   next_cmd = CMD_PRE;
        REQ_REF:   next_cmd = CMD_REF;
        REQ_SELF:  next_cmd = CMD_REF;
        REQ_EXIT:  next_cmd = CMD_NOP;
        default:   next_cmd = CMD_NOP;
      endcase
    end
  end
  wire modeSent = tick && pendMode && inRun;
  wire cmdNow   = issue || modeSent;

  always_ff @(posedge mclk) begin
    clkSync   <= {clkSync[1:0], sdClk};
    dataSync1 <= sdDataIn;
    dataSync2 <= dataSync1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl <= ctrlWrVal;
    end
  end

  // Mode value has no reset and no readback
  always_ff @(posedge mclk) begin
    if (modeWr) begin
      modeValue <= busAddr[MODE_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busAck   <= 1'b0;
      busRdata <= 32'h0000_0000;
    end else begin
      busAck   <= busSel;
      busRdata <= (ctrlHit && !busWe) ? ctrl : 32'h0000_0000;
    end
  end

  // Pending register-driven commands; a new write wins over completion
  always_ff @(posedge mclk) begin
    if (reset) begin
      pendMode    <= 1'b0;
      pendExitPd  <= 1'b0;
      pendEnterPd <= 1'b0;
    end else begin
      pendMode    <= modeWr || (pendMode && !modeSent);
      pendExitPd  <= ckeRise || (pendExitPd && !tick);
      pendEnterPd <= (ckeFall && clockOutputEnable) || (pendEnterPd && !tick);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sdPins <= '{cmd: CMD_NOP, addr: '0, cke: 1'b0};
    end else if (tick) begin
      sdPins.cmd  <= next_cmd;
      sdPins.addr <= next_addr;
      sdPins.cke  <= ctrl[CKE_LEVEL_BIT] && !(state == ST_SELF)
                     && !(issue && req.kind == REQ_SELF);
    end
  end

  // Timing counters, counted in SDRAM clock cycles
  always_ff @(posedge mclk) begin
    if (reset) begin
      actWait  <= 5'h00;
      rwWait   <= 5'h00;
      ckeWait  <= 5'h00;
      exitWait <= 5'h00;
    end else if (tick) begin
      actWait  <= (actWait != 5'h00) ? actWait - 5'h01 : 5'h00;
      rwWait   <= (rwWait != 5'h00) ? rwWait - 5'h01 : 5'h00;
      ckeWait  <= (ckeWait != 5'h00) ? ckeWait - 5'h01 : 5'h00;
      exitWait <= (exitWait != 5'h00) ? exitWait - 5'h01 : 5'h00;
      if (modeSent && !ctrl[MODE_SET_BIT]) begin
        actWait <= preActN;
      end else if (issue) begin
        unique case (req.kind)
          REQ_ACT:   rwWait  <= actRwN;
          REQ_PRE:   actWait <= preActN;
          REQ_WRITE: actWait <= wrActN;
          REQ_REF:   actWait <= refActN;
          REQ_SELF:  ckeWait <= ckeLowN;
          REQ_EXIT:  exitWait <= refActN;
          default:   actWait <= actWait;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_RUN;
    end else if (tick) begin
      unique case (state)
        ST_RUN:  if (issue && req.kind == REQ_SELF) state <= ST_SELF;
        ST_SELF: if (issue) state <= ST_EXIT;
        ST_EXIT: if (exitWait == 5'h00) state <= ST_RUN;
        default: state <= ST_RUN;
      endcase
    end
  end

  // Read capture after programmed latency
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdBusy    <= 1'b0;
      rdCount   <= 2'h0;
      readValid <= 1'b0;
      readData  <= '0;
    end else begin
      readValid <= 1'b0;
      if (tick && issue && req.kind == REQ_READ) begin
        rdBusy  <= 1'b1;
        rdCount <= rdLat;
      end else if (tick && rdBusy) begin
        if (rdCount == 2'h0) begin
          rdBusy    <= 1'b0;
          readValid <= 1'b1;
          readData  <= dataSync2;
        end else begin
          rdCount <= rdCount - 2'h1;
        end
      end
    end
  end
endmodule

// ===== hw/sdts_pkg.sv
// Package for SDRAM timing and mode setup: offsets, fields, encodings, types
package sdts_pkg;
  localparam logic [15:0] CTRL_OFFSET     = 16'h0080;
  localparam logic [15:0] MODE_BASE       = 16'hA000;
  localparam logic [15:0] MODE_SPAN_MASK  = 16'hFC00;
  localparam int          MODE_W          = 10;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  // Held bits: mode_set_select, cke_level_control, timing fields; 16 and 7 stay zero
  localparam logic [31:0] CTRL_HELD_MASK  = 32'h0082_FF7F;
  localparam int          MODE_SET_BIT    = 23;
  localparam int          CKE_LEVEL_BIT   = 17;
  localparam int          CKE_LOW_LSB     = 13;
  localparam int          ACT_RW_LSB      = 11;
  localparam int          PRE_ACT_LSB     = 8;
  localparam int          WR_REC_LSB      = 5;
  localparam int          REF_ACT_LSB     = 2;
  localparam int          RD_LAT_LSB      = 0;
  localparam logic [4:0]  CKE_LOW_BASE    = 5'h04;
  localparam logic [1:0]  RD_LAT_TWO      = 2'h1;
  localparam logic [1:0]  RD_LAT_THREE    = 2'h2;
  localparam int          ADDR_W          = 15;
  localparam int          PALL_ADDR_BIT   = 10;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } sdts_cmd_t;

  localparam sdts_cmd_t CMD_NOP   = 4'h7;
  localparam sdts_cmd_t CMD_ACT   = 4'h3;
  localparam sdts_cmd_t CMD_READ  = 4'h5;
  localparam sdts_cmd_t CMD_WRITE = 4'h4;
  localparam sdts_cmd_t CMD_PRE   = 4'h2;
  localparam sdts_cmd_t CMD_REF   = 4'h1;
  localparam sdts_cmd_t CMD_MRS   = 4'h0;

  typedef enum logic [2:0] {
    REQ_ACT   = 3'h0,
    REQ_READ  = 3'h1,
    REQ_WRITE = 3'h2,
    REQ_PRE   = 3'h3,
    REQ_REF   = 3'h4,
    REQ_SELF  = 3'h5,
    REQ_EXIT  = 3'h6
  } sdts_req_e;

  typedef struct packed {
    sdts_req_e          kind;
    logic [ADDR_W-1:0]  addr;
  } sdts_req_t;

  typedef struct packed {
    sdts_cmd_t          cmd;
    logic [ADDR_W-1:0]  addr;
    logic               cke;
  } sdts_pins_t;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_SELF = 3'b010,
    ST_EXIT = 3'b100
  } sdts_state_e;
endpackage

// ===== verif/sdts_core_asserts.sv
// Checker for the SDRAM timing and mode setup ports
`timescale 1ns/1ps
module sdts_core_asserts (
  input wire logic                 mclk,
  input wire logic                 reset,
  input wire logic                 busSel,
  input wire logic                 busAck,
  input wire logic [31:0]          busRdata,
  input wire logic                 reqValid,
  input wire logic                 reqReady,
  input wire sdts_pkg::sdts_req_t  req,
  input wire sdts_pkg::sdts_pins_t sdPins,
  input wire logic                 readValid
);
  import sdts_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    reset |=> sdPins.cmd == CMD_NOP && !sdPins.cke && !busAck) else $error("pins not idle");
  AST_BUS_ACK: assert property (1'b1 |=> busAck == $past(busSel)) else $error("bad ack");
  AST_RSVD_ZERO: assert property (busAck |-> !busRdata[16] && !busRdata[7])
    else $error("reserved bit set");
  AST_READY_PULSE: assert property (reqReady |-> reqValid ##1 !reqReady)
    else $error("bad ready");
  AST_ACT_ISSUE: assert property (reqReady && req.kind == REQ_ACT
    |=> sdPins.cmd == CMD_ACT && sdPins.addr == $past(req.addr)) else $error("act missing");
  AST_READ_ISSUE: assert property (reqReady && req.kind == REQ_READ
    |=> sdPins.cmd == CMD_READ) else $error("read missing");
  AST_SELF_CKE: assert property (reqReady && req.kind == REQ_SELF |=> !sdPins.cke [*8])
    else $error("cke high in self refresh");
  AST_CMD_HOLD: assert property ($changed(sdPins) |=> $stable(sdPins) [*8])
    else $error("command too short");
  AST_READ_PULSE: assert property (readValid |=> !readValid) else $error("long pulse");
  COV_MRS: cover property (sdPins.cmd == CMD_MRS);
  COV_READ: cover property (readValid);
  COV_SELF: cover property (reqReady && req.kind == REQ_SELF);
endmodule
bind sdts_core sdts_core_asserts sdts_core_asserts_inst (.mclk(mclk), .reset(reset),
  .busSel(busSel), .busAck(busAck), .busRdata(busRdata), .reqValid(reqValid),
  .reqReady(reqReady), .req(req), .sdPins(sdPins), .readValid(readValid));

// ===== verif/sdts_sdram_model.sv
// Behavioural SDRAM chip: bus clock and read data
`timescale 1ns/1ps
module sdts_sdram_model (
  output logic                      sdClk,
  input  wire sdts_pkg::sdts_pins_t sdPins,
  output logic [31:0]               sdDataIn
);
  import sdts_pkg::*;
  logic [2:0]  lat = 3'h0;
  logic [2:0]  cnt = 3'h0;
  logic [14:0] col = 15'h0;
  wire         rd = sdPins.cke && sdPins.cmd == CMD_READ;
  initial begin
    sdClk = 1'b0;
    sdDataIn = 32'h0;
    #3;
    forever #80 sdClk = ~sdClk;
  end
  // Data held two clocks around the latency point, toggling otherwise
  always @(posedge sdClk) begin
    if (sdPins.cke && sdPins.cmd == CMD_MRS) lat <= sdPins.addr[6:4];
    if (rd) col <= sdPins.addr;
    cnt <= rd ? lat : ((cnt != 3'h0) ? cnt - 3'h1 : cnt);
    sdDataIn <= (cnt == 3'h2 || cnt == 3'h1) ? {17'h1A5A5, col} : ~sdDataIn;
  end
endmodule

// ===== verif/tb_sdts_core.sv
// Testbench for SDRAM timing and mode setup
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_sdts_core;
  import sdts_pkg::*;
  localparam logic [31:0] CTRL_VAL = 32'h0002_4B45;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        busSel = 1'b0;
  logic        busWe = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqReady;
  logic        busAck;
  logic        readValid;
  logic        sdClk;
  logic [15:0] busAddr = 16'h0;
  logic [31:0] busWdata = 32'h0;
  logic [31:0] busRdata;
  logic [31:0] sdDataIn;
  logic [31:0] readData;
  sdts_req_t   req = '0;
  sdts_pins_t  sdPins;
  int          miscompares = 0;
  int          checks = 0;
  int          t0;
  int          t1;
  int          n;
  always #5 mclk = ~mclk;
  sdts_core sdts_core_inst (.mclk(mclk), .reset(reset), .busSel(busSel), .busWe(busWe),
    .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata), .busAck(busAck),
    .clockOutputEnable(1'b1), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .sdClk(sdClk), .sdPins(sdPins), .sdDataIn(sdDataIn), .readData(readData),
    .readValid(readValid));
  sdts_sdram_model sdts_sdram_model_inst (.sdClk(sdClk), .sdPins(sdPins), .sdDataIn(sdDataIn));
  task automatic end_of_test();
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    busSel <= 1'b1;
    busWe <= we;
    busAddr <= a;
    busWdata <= d;
    @(posedge mclk);
    busSel <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic waitPins(input logic [4:0] v);
    for (n = 0; n < 400 && {sdPins.cmd, sdPins.cke} !== v; n++) @(negedge mclk);
    if (n >= 400) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic issue(input sdts_req_e k, input logic [14:0] a, output int t);
    @(posedge mclk);
    reqValid <= 1'b1;
    req <= '{kind: k, addr: a};
    for (n = 0; n < 3000 && reqReady !== 1'b1; n++) @(negedge mclk);
    if (n >= 3000) begin
      miscompares++;
      end_of_test();
    end
    @(posedge mclk);
    reqValid <= 1'b0;
    t = int'($time);
  endtask
  task automatic waitRead();
    for (n = 0; n < 400 && readValid !== 1'b1; n++) @(negedge mclk);
    if (n >= 400) begin
      miscompares++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl reset", 32'h0, busRdata)
    bus(1'b1, CTRL_OFFSET, 32'hFFFF_FFFF);
    bus(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl mask", CTRL_HELD_MASK, busRdata)
    bus(1'b0, MODE_BASE + 16'h022, 32'h0);
    `CHK("window read", 32'h0, busRdata)
    bus(1'b1, CTRL_OFFSET, 32'h0);
    waitPins({CMD_NOP, 1'b0});
    bus(1'b1, CTRL_OFFSET, CTRL_VAL);
    waitPins({CMD_NOP, 1'b1});
    bus(1'b1, MODE_BASE + 16'h022, 32'hFFFF_FFFF);
    waitPins({CMD_PRE, 1'b1});
    `CHK("precharge all", 1'b1, sdPins.addr[PALL_ADDR_BIT])
    bus(1'b1, CTRL_OFFSET, CTRL_VAL | 32'h0080_0000);
    bus(1'b1, MODE_BASE + 16'h022, 32'h0);
    waitPins({CMD_MRS, 1'b1});
    `CHK("mode value", 15'h022, sdPins.addr)
    issue(REQ_PRE, 15'h0, t0);
    issue(REQ_ACT, 15'h0123, t1);
    `CHK("pre to act", 4, (t1 - t0) / 160)
    issue(REQ_READ, 15'h0005, t0);
    `CHK("act to read", 2, (t0 - t1) / 160)
    waitRead();
    `CHK("read latency", 2, (int'($time) - t0) / 160)
    `CHK("read data", {17'h1A5A5, 15'h0005}, readData)
    issue(REQ_WRITE, 15'h0009, t0);
    issue(REQ_ACT, 15'h0123, t1);
    `CHK("write to act", 7, (t1 - t0) / 160)
    issue(REQ_REF, 15'h0, t0);
    issue(REQ_ACT, 15'h0123, t1);
    `CHK("refresh to act", 3, (t1 - t0) / 160)
    issue(REQ_SELF, 15'h0, t0);
    issue(REQ_EXIT, 15'h0, t1);
    `CHK("cke low time", 1'b1, (t1 - t0) / 160 >= 6)
    issue(REQ_ACT, 15'h0123, t0);
    `CHK("exit delay", 1'b1, (t0 - t1) / 160 >= 3)
    bus(1'b1, CTRL_OFFSET, (CTRL_VAL & 32'hFFFF_FFFC) | 32'h0080_0002);
    bus(1'b1, MODE_BASE + 16'h032, 32'h0);
    waitPins({CMD_MRS, 1'b1});
    `CHK("mode value three", 15'h032, sdPins.addr)
    issue(REQ_READ, 15'h0011, t0);
    waitRead();
    `CHK("read latency three", 3, (int'($time) - t0) / 160)
    `CHK("read data three", {17'h1A5A5, 15'h0011}, readData)
    end_of_test();
  end
endmodule
